// ==== src/fifo_alloc_consts.vh ====
`ifndef FIFO_ALLOC_CONSTS_VH
`define FIFO_ALLOC_CONSTS_VH
// ==========================================================
// Register byte addresses.
`define HWC_ADDR 8'h74
`define RDP_ADDR 8'h78
`define ALLOC_ADDR 8'h90
`define IST_ADDR 8'h94
`define IMASK_ADDR 8'h98
`define DROP_ADDR 8'h9C
// ==========================================================
// Field positions.
`define HWC_SRST_BIT 0
`define HWC_TO_BIT 1
`define HWC_TXSZ 19:16
`define RDP_SKIP_BIT 31
`define ALLOC_TXD 11:0
`define ALLOC_RXD 27:16
`define IRQ_TO_BIT 0
`define IRQ_DROP_BIT 1
`define IRQ_SKIP_BIT 2
`define IRQ_SRST_BIT 3
`define IRQ_BITS 3:0
`define DROP_BITS 15:0
// ==========================================================
// Reset values.
`define TXSZ_RST 4'h5
`define IRQ_RST 4'h0
`define DROP_RST 16'h0000
// ==========================================================
// Buffer sizes and margin in DWORDs; staging address widths in bits.
`define BUF_DW 13'h1000
`define TXSTAT_DW 12'h080
`define RX_FULL_MARGIN 12'h004
`define RXSTAGE_AW 5
`define RXSTAGE_DEPTH 6'h20
`define TXSTAGE_AW 9
`define TXSTAGE_DEPTH 10'h200
// ==========================================================
// Timing.
`define CLK_NS 10
`define SRST_TIMEOUT_NS 2560
`define SRST_TIMEOUT_CYC ((`SRST_TIMEOUT_NS + `CLK_NS - 1) / `CLK_NS)
`define SRST_HOLD_CYC 8
`endif

// ==== src/stage_mem.v ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Simple dual port memory with a registered read port.
module stage_mem #(
  parameter W = 32,
  parameter AW = 5
) (
  input wire sys_clk,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [W-1:0] wdata,
  input wire re,
  input wire [AW-1:0] raddr,
  output reg [W-1:0] rdata
);
  reg [W-1:0] mem [0:(1<<AW)-1];

  // Write port, then read port holding its word until the next read.
  always @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      rdata <= mem[raddr];
    end
  end
endmodule // stage_mem
`default_nettype wire

// ==== src/soft_reset_seq.v ====
`timescale 1ns/10ps
`default_nettype none
`include "fifo_alloc_consts.vh"
// ==========================================================
// Soft reset sequencer: waits for running PHY clocks, else times out.
module soft_reset_seq (
  input wire sys_clk,
  input wire rst,
  input wire start,
  input wire phy_ok,
  output reg busy,
  output reg done,
  output reg timeout,
  output reg reset_out
);
  localparam [1:0] S_IDLE = 2'b00;
  localparam [1:0] S_WAIT = 2'b01;
  localparam [1:0] S_HOLD = 2'b10;
  // Counts are worked out as integers, then cut to the counter width on purpose.
  localparam integer TO_CYC_I = `SRST_TIMEOUT_CYC;
  localparam integer HOLD_CYC_I = `SRST_HOLD_CYC;
  localparam [8:0] TO_CYC = TO_CYC_I[8:0];
  localparam [8:0] HOLD_CYC = HOLD_CYC_I[8:0];
  reg [1:0] state_r;
  reg [8:0] cnt_r;

  // Sequence: wait for clocks, hold the reset, then finish or abandon.
  always @(posedge sys_clk) begin
    done <= 1'b0;
    timeout <= 1'b0;
    if (rst) begin
      state_r <= S_IDLE;
      cnt_r <= 9'h000;
      busy <= 1'b0;
      reset_out <= 1'b0;
    end else begin
      case (state_r)
        S_IDLE: begin
          cnt_r <= 9'h000;
          if (start) begin
            busy <= 1'b1;
            state_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          cnt_r <= cnt_r + 9'h001;
          if (phy_ok) begin
            cnt_r <= 9'h000;
            reset_out <= 1'b1;
            state_r <= S_HOLD;
          end else if (cnt_r == TO_CYC - 9'h001) begin
            busy <= 1'b0; // [R1]
            timeout <= 1'b1; // [R1]
            state_r <= S_IDLE;
          end
        end
        S_HOLD: begin
          cnt_r <= cnt_r + 9'h001;
          if (cnt_r == HOLD_CYC - 9'h001) begin
            reset_out <= 1'b0;
            busy <= 1'b0; // [R3]
            done <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule // soft_reset_seq
`default_nettype wire

// ==== src/fifo_alloc_ctrl.v ====
// Notes on behaviour
// [R1] Soft reset with stopped PHY clocks is abandoned and sets the time-out flag.
// [R2] After a time-out the host fixes the PHY and requests reset again.
// [R3] Soft reset clears registers except unaffected bits; the request bit self-clears.
// [R4] Host requests soft reset only with the PHY fully running.
// [R5] Writes are ignored until one read follows reset or power-save exit.
// [R6] Transmit size in KB includes a fixed 128-DWORD status FIFO.
// [R7] Transmit data space holds both command words and payload.
// [R8] Receive allocation is the 16384-byte buffer minus transmit allocation.
// [R9] Receive status takes one sixteenth of receive allocation, data the rest.
// [R10] Host programs transmit size only from 2 through 14.
// [R11] Receive data FIFO counts as full 4 DWORDs before its size.
// [R12] Fixed staging buffers: 2K bytes transmit, 128 bytes receive.
// [R13] Transmit staging fills from the data FIFO as space frees.
// [R14] Receive data stages then drains; it accumulates while the FIFO is full.
// [R15] On staging overrun, frames drop until space frees; each counted once.
// [R16] Staging levels are hidden and excluded from reported FIFO levels.
// [R17] Writing bit 31 skips to next frame; reads high until done.
// [R18] Host does not read receive data while the skip bit is high.
// [R19] Receive control bits 30 to 0 read zero and ignore writes.
`timescale 1ns/10ps
`default_nettype none
`include "fifo_alloc_consts.vh"
module fifo_alloc_ctrl (
  input wire sys_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg irq,
  input wire phy_clocks_running,
  input wire power_save_exit,
  output reg mac_soft_reset,
  output reg [11:0] tx_data_size_dw,
  output reg [11:0] rx_data_size_dw,
  output reg [11:0] rx_status_size_dw,
  input wire tx_fifo_valid,
  input wire [31:0] tx_fifo_data,
  output reg tx_fifo_ready,
  output reg tx_mac_valid,
  output wire [31:0] tx_mac_data,
  input wire tx_mac_ready,
  input wire rx_mac_valid,
  input wire [31:0] rx_mac_data,
  input wire rx_mac_last,
  input wire [11:0] rx_fifo_used_dw,
  output reg rx_fifo_wr_valid,
  output wire [31:0] rx_fifo_wr_data,
  output wire rx_fifo_wr_last,
  output reg rx_skip_req,
  input wire rx_skip_done
);
  // ==========================================================
  // Register state.
  reg [3:0] txsz_r;
  reg to_flag_r;
  reg read_seen_r;
  reg skip_busy_r;
  reg [3:0] ist_r;
  reg [3:0] imask_r;
  reg [15:0] drop_cnt_r;
  wire srst_busy;
  wire srst_done;
  wire soft_reset_timeout_flag;
  wire srst_pulse;
  wire soft_rst;

  // Hard reset or the sequencer's hold both clear the datapath.
  assign soft_rst = rst | srst_pulse; // [R3]

  // ==========================================================
  // APB decode.
  wire acc_go;
  wire wr_go;
  wire rd_go;
  wire mapped;
  assign acc_go = psel & penable & pready;
  assign rd_go = acc_go & ~pwrite;
  assign wr_go = acc_go & pwrite & read_seen_r; // [R5]
  assign mapped = (paddr == `HWC_ADDR) | (paddr == `RDP_ADDR) |
    (paddr == `ALLOC_ADDR) | (paddr == `IST_ADDR) |
    (paddr == `IMASK_ADDR) | (paddr == `DROP_ADDR);

  // ==========================================================
  // Allocation arithmetic in DWORDs.
  reg [12:0] tx_tot_dw;
  reg [12:0] rx_tot_dw;
  reg [12:0] rx_stat_dw;
  reg [12:0] rx_data_dw;

  // Split the shared buffer from the transmit size field.
  always @* begin
    tx_tot_dw = {1'b0, txsz_r, 8'h00}; // [R6]
    rx_tot_dw = `BUF_DW - tx_tot_dw; // [R8]
    rx_stat_dw = {4'h0, rx_tot_dw[12:4]}; // [R9]
    rx_data_dw = rx_tot_dw - rx_stat_dw; // [R9]
  end

  // Publish sizes; transmit data space carries commands and payload.
  always @(posedge sys_clk) begin
    tx_data_size_dw <= tx_tot_dw[11:0] - `TXSTAT_DW; // [R6] [R7]
    rx_data_size_dw <= rx_data_dw[11:0];
    rx_status_size_dw <= rx_stat_dw[11:0];
  end

  // Full threshold sits four DWORDs below the data size.
  wire rx_full;
  assign rx_full = rx_fifo_used_dw >= (rx_data_size_dw - `RX_FULL_MARGIN); // [R11]

  // ==========================================================
  // APB answer: one wait state, then registered data and error.
  always @(posedge sys_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata <= 32'h00000000;
      if (psel & penable & ~pready & ~pwrite) begin
        case (paddr)
          `HWC_ADDR: begin
            prdata[`HWC_TXSZ] <= txsz_r;
            prdata[`HWC_TO_BIT] <= to_flag_r;
            prdata[`HWC_SRST_BIT] <= srst_busy; // [R3]
          end
          `RDP_ADDR: begin
            prdata[`RDP_SKIP_BIT] <= skip_busy_r; // [R17] [R19]
          end
          `ALLOC_ADDR: begin
            prdata[`ALLOC_TXD] <= tx_data_size_dw;
            prdata[`ALLOC_RXD] <= rx_data_size_dw;
          end
          `IST_ADDR: begin
            prdata[`IRQ_BITS] <= ist_r;
          end
          `IMASK_ADDR: begin
            prdata[`IRQ_BITS] <= imask_r;
          end
          `DROP_ADDR: begin
            prdata[`DROP_BITS] <= drop_cnt_r;
          end
          default: begin
            prdata <= 32'h00000000;
          end
        endcase
      end
    end
  end

  // Writes unlock after the first completed read.
  always @(posedge sys_clk) begin
    if (rst | power_save_exit) begin
      read_seen_r <= 1'b0; // [R5]
    end else if (rd_go) begin
      read_seen_r <= 1'b1; // [R5]
    end
  end

  // ==========================================================
  // Configuration and mask survive a soft reset.
  always @(posedge sys_clk) begin
    if (rst) begin
      txsz_r <= `TXSZ_RST;
      imask_r <= `IRQ_RST;
      to_flag_r <= 1'b0;
    end else begin
      if (wr_go && paddr == `HWC_ADDR) begin
        txsz_r <= pwdata[`HWC_TXSZ];
      end
      if (wr_go && paddr == `IMASK_ADDR) begin
        imask_r <= pwdata[`IRQ_BITS];
      end
      if (soft_reset_timeout_flag) begin
        to_flag_r <= 1'b1; // [R1]
      end else if (srst_done) begin
        to_flag_r <= 1'b0;
      end
    end
  end

  // Soft reset request bit starts the sequencer.
  wire srst_start;
  assign srst_start = wr_go && paddr == `HWC_ADDR && pwdata[`HWC_SRST_BIT];

  soft_reset_seq u_srst (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(srst_start),
    .phy_ok(phy_clocks_running),
    .busy(srst_busy),
    .done(srst_done),
    .timeout(soft_reset_timeout_flag),
    .reset_out(srst_pulse)
  );

  // Drive the reset out to the MAC and system registers.
  always @(posedge sys_clk) begin
    if (rst) begin
      mac_soft_reset <= 1'b0;
    end else begin
      mac_soft_reset <= srst_pulse; // [R3]
    end
  end

  // ==========================================================
  // Receive skip: pulse request, hold busy until done.
  wire skip_wr;
  assign skip_wr = wr_go && paddr == `RDP_ADDR && pwdata[`RDP_SKIP_BIT];
  always @(posedge sys_clk) begin
    if (soft_rst) begin
      skip_busy_r <= 1'b0;
      rx_skip_req <= 1'b0;
    end else begin
      rx_skip_req <= skip_wr; // [R17]
      if (skip_wr) begin
        skip_busy_r <= 1'b1; // [R17]
      end else if (rx_skip_done) begin
        skip_busy_r <= 1'b0; // [R17]
      end
    end
  end

  // ==========================================================
  // Transmit staging buffer, 512 DWORDs.
  reg [8:0] txw_r;
  reg [8:0] txr_r;
  reg [9:0] txc_r;
  reg [9:0] txc_nxt;
  wire tx_wr;
  wire tx_rd;
  assign tx_wr = tx_fifo_valid & tx_fifo_ready; // [R13]
  assign tx_rd = (txc_r != 10'h000) & (~tx_mac_valid | tx_mac_ready);

  // Occupancy follows pushes and pops.
  always @* begin
    txc_nxt = txc_r;
    if (tx_wr & ~tx_rd) begin
      txc_nxt = txc_r + 10'h001;
    end else if (tx_rd & ~tx_wr) begin
      txc_nxt = txc_r - 10'h001;
    end
  end

  // Pull from the data FIFO whenever staging has room.
  always @(posedge sys_clk) begin
    if (soft_rst) begin
      txw_r <= 9'h000;
      txr_r <= 9'h000;
      txc_r <= 10'h000;
      tx_fifo_ready <= 1'b0;
      tx_mac_valid <= 1'b0;
    end else begin
      txc_r <= txc_nxt;
      tx_fifo_ready <= (txc_nxt < `TXSTAGE_DEPTH - 10'h001); // [R13]
      if (tx_wr) begin
        txw_r <= txw_r + 9'h001;
      end
      if (tx_rd) begin
        txr_r <= txr_r + 9'h001;
      end
      tx_mac_valid <= tx_rd | (tx_mac_valid & ~tx_mac_ready);
    end
  end

  stage_mem #(.W(32), .AW(`TXSTAGE_AW)) u_txmem ( // [R12]
    .sys_clk(sys_clk),
    .we(tx_wr),
    .waddr(txw_r),
    .wdata(tx_fifo_data),
    .re(tx_rd),
    .raddr(txr_r),
    .rdata(tx_mac_data)
  );

  // ==========================================================
  // Receive staging buffer, 32 DWORDs plus a last flag.
  reg [4:0] rxw_r;
  reg [4:0] rxr_r;
  reg [5:0] rxc_r;
  reg start_r;
  reg disc_r;
  reg drop_mode_r;
  wire frame_disc;
  wire rx_stage_full;
  wire rx_wr;
  wire rx_ovr;
  wire rx_rd;
  wire rx_lost;
  assign rx_stage_full = (rxc_r == `RXSTAGE_DEPTH);
  assign frame_disc = start_r ? (drop_mode_r & rx_full) : disc_r; // [R15]
  assign rx_wr = rx_mac_valid & ~frame_disc & ~rx_stage_full; // [R14]
  assign rx_ovr = rx_mac_valid & ~frame_disc & rx_stage_full; // [R15]
  assign rx_rd = (rxc_r != 6'h00) & ~rx_full; // [R14]
  assign rx_lost = rx_mac_valid & rx_mac_last & (frame_disc | rx_ovr);

  // Track frames, overruns and the staging level.
  always @(posedge sys_clk) begin
    if (soft_rst) begin
      rxw_r <= 5'h00;
      rxr_r <= 5'h00;
      rxc_r <= 6'h00;
      start_r <= 1'b1;
      disc_r <= 1'b0;
      drop_mode_r <= 1'b0;
      rx_fifo_wr_valid <= 1'b0;
      drop_cnt_r <= `DROP_RST;
    end else begin
      if (rx_wr) begin
        rxw_r <= rxw_r + 5'h01;
      end
      if (rx_rd) begin
        rxr_r <= rxr_r + 5'h01;
      end
      if (rx_wr & ~rx_rd) begin
        rxc_r <= rxc_r + 6'h01;
      end else if (rx_rd & ~rx_wr) begin
        rxc_r <= rxc_r - 6'h01;
      end
      rx_fifo_wr_valid <= rx_rd;
      if (rx_mac_valid) begin
        start_r <= rx_mac_last;
        disc_r <= frame_disc | rx_ovr;
      end
      if (rx_ovr) begin
        drop_mode_r <= 1'b1; // [R15]
      end else if (rx_mac_valid & start_r & ~rx_full) begin
        drop_mode_r <= 1'b0; // [R15]
      end
      if (rx_lost) begin
        drop_cnt_r <= drop_cnt_r + 16'h0001; // [R15]
      end
    end
  end

  stage_mem #(.W(33), .AW(`RXSTAGE_AW)) u_rxmem ( // [R12] [R16]
    .sys_clk(sys_clk),
    .we(rx_wr),
    .waddr(rxw_r),
    .wdata({rx_mac_last, rx_mac_data}),
    .re(rx_rd),
    .raddr(rxr_r),
    .rdata({rx_fifo_wr_last, rx_fifo_wr_data})
  );

  // ==========================================================
  // Interrupt status: sticky, write one to clear, set wins.
  wire [3:0] ev;
  wire [3:0] clr;
  assign ev = {srst_done, skip_busy_r & rx_skip_done, rx_lost, soft_reset_timeout_flag};
  assign clr = (wr_go && paddr == `IST_ADDR) ? pwdata[`IRQ_BITS] : 4'h0;
  always @(posedge sys_clk) begin
    if (soft_rst) begin
      ist_r <= `IRQ_RST;
      irq <= 1'b0;
    end else begin
      ist_r <= (ist_r & ~clr) | ev;
      irq <= |(((ist_r & ~clr) | ev) & imask_r);
    end
  end
endmodule // fifo_alloc_ctrl
`default_nettype wire

// ==== tb/fifo_alloc_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fifo_alloc_consts.vh"
// =====
// Port checker.
module fifo_alloc_checker (
  input wire sys_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire power_save_exit,
  input wire phy_clocks_running,
  input wire mac_soft_reset,
  input wire [11:0] tx_data_size_dw,
  input wire [11:0] rx_data_size_dw,
  input wire [11:0] rx_status_size_dw,
  input wire tx_fifo_ready,
  input wire tx_mac_valid,
  input wire [31:0] tx_mac_data,
  input wire tx_mac_ready,
  input wire [11:0] rx_fifo_used_dw,
  input wire rx_fifo_wr_valid,
  input wire rx_skip_req
);
  logic rd_seen;
  wire skip_wr = psel && penable && pready && pwrite && paddr == `RDP_ADDR && pwdata[31];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Tracks whether a read has unlocked writes.
  always @(posedge sys_clk) begin
    if (rst || power_save_exit) rd_seen <= 1'b0;
    else if (psel && penable && pready && !pwrite) rd_seen <= 1'b1;
  end
  property p_skip; skip_wr && rd_seen |=> rx_skip_req; endproperty
  a_skip: assert property (p_skip) else $error("skip request missing");
  property p_lock; skip_wr && !rd_seen |=> !rx_skip_req; endproperty
  a_lock: assert property (p_lock) else $error("write before read acted");
  property p_phy; $rose(mac_soft_reset) |-> $past(phy_clocks_running); endproperty
  a_phy: assert property (p_phy) else $error("reset with PHY stopped");
  property p_hold; $rose(mac_soft_reset) |-> mac_soft_reset [*8] ##1 !mac_soft_reset;
  endproperty
  a_hold: assert property (p_hold) else $error("soft reset hold wrong");
  property p_sum; !$past(rst) && !$past(rst, 2) |->
    tx_data_size_dw + rx_data_size_dw + rx_status_size_dw == 12'hF80; endproperty
  a_sum: assert property (p_sum) else $error("allocation sum wrong");
  property p_st; !$past(rst) && !$past(rst, 2) |->
    {4'h0, rx_status_size_dw} * 16'h000F == {4'h0, rx_data_size_dw}; endproperty
  a_st: assert property (p_st) else $error("status share wrong");
  property p_full; rx_fifo_wr_valid |->
    {1'b0, $past(rx_fifo_used_dw)} + 13'h0004 < {1'b0, $past(rx_data_size_dw)}; endproperty
  a_full: assert property (p_full) else $error("push while full");
  property p_txh; tx_mac_valid && !tx_mac_ready |=> tx_mac_valid && $stable(tx_mac_data);
  endproperty
  a_txh: assert property (p_txh) else $error("transmit word dropped");
  property p_room; $fell(rst) |=> tx_fifo_ready; endproperty
  a_room: assert property (p_room) else $error("no staging room");
endmodule // fifo_alloc_checker
bind fifo_alloc_ctrl fifo_alloc_checker chk (.*);
`default_nettype wire

// ==== tb/mac_side_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// =====
// MAC side: answers skips late, takes transmit words with stalls.
module mac_side_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic rx_skip_req,
  output logic rx_skip_done,
  input wire logic tx_mac_valid,
  input wire logic [31:0] tx_mac_data,
  output logic tx_mac_ready,
  output logic [3:0] tx_count,
  output logic [31:0] tx_last
);
  logic [4:0] wait_r;
  // Skip completes twenty cycles after the request.
  always @(posedge sys_clk) begin
    if (rst) begin
      wait_r <= 5'h00;
      rx_skip_done <= 1'b0;
      tx_mac_ready <= 1'b0;
      tx_count <= 4'h0;
      tx_last <= 32'h0;
    end else begin
      rx_skip_done <= wait_r == 5'h01;
      if (rx_skip_req) wait_r <= 5'h14;
      else if (wait_r != 5'h00) wait_r <= wait_r - 5'h01;
      tx_mac_ready <= stall ? !tx_mac_ready : 1'b1;
      if (tx_mac_valid && tx_mac_ready) begin
        tx_count <= tx_count + 4'h1;
        tx_last <= tx_mac_data;
      end
    end
  end
endmodule // mac_side_model
`default_nettype wire

// ==== tb/mac_fifo_allocation_and_soft_reset_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fifo_alloc_consts.vh"
// =====
// Bench for the allocation and soft reset block.
module mac_fifo_allocation_and_soft_reset_tb;
  logic sys_clk, rst, psel, penable, pwrite, irq, pready, pslverr, e, stall;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, tx_fifo_data, tx_mac_data, rx_mac_data, rx_fifo_wr_data, tx_last;
  logic phy_clocks_running, power_save_exit, mac_soft_reset, tx_fifo_valid, tx_fifo_ready;
  logic tx_mac_valid, tx_mac_ready, rx_mac_valid, rx_mac_last, rx_fifo_wr_valid, rx_fifo_wr_last;
  logic rx_skip_req, rx_skip_done;
  logic [11:0] tx_data_size_dw, rx_data_size_dw, rx_status_size_dw, rx_fifo_used_dw, r;
  logic [3:0] tx_count;
  logic [31:0] rxd_seen;
  int mismatches, check_count, cycles, pushes, lasts;
  fifo_alloc_ctrl uut (.*);
  mac_side_model partner (.*);
  // Clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Counts receive pushes and cuts a hang short.
  always @(posedge sys_clk) begin
    cycles++;
    if (rx_fifo_wr_valid === 1'b1) pushes++;
    if (rx_fifo_wr_valid === 1'b1 && rx_fifo_wr_last === 1'b1) lasts++;
    if (rx_fifo_wr_valid === 1'b1) rxd_seen = rx_fifo_wr_data;
    if (cycles == 20000) begin
      mismatches++;
      stop_test;
    end
  end
  task stop_test;
    if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task poll(input logic [7:0] a, input logic [31:0] m);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((q & m) !== 32'h0 && n < 80);
  endtask
  task frame(input int n);
    for (int i = 0; i < n; i++) begin
      rx_mac_valid <= 1'b1;
      rx_mac_data <= 32'(i) + 32'h100;
      rx_mac_last <= i == n - 1;
      @(posedge sys_clk);
    end
    rx_mac_valid <= 1'b0;
    rx_mac_last <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Read lock, reset sizes, every legal size, unmapped address.
  task test_alloc;
    chk(32'(tx_data_size_dw), 32'h480);
    chk(32'(rx_data_size_dw), 32'hA50);
    chk(32'(rx_status_size_dw), 32'hB0);
    wr(`HWC_ADDR, 32'h0008_0000);
    rd(`HWC_ADDR, 32'h0005_0000);
    for (int k = 2; k <= 14; k++) begin
      wr(`HWC_ADDR, 32'(k) << 16);
      r = 12'(4096 - k * 256);
      rd(`ALLOC_ADDR, {4'h0, r - r / 16, 4'h0, 12'(k * 256 - 128)});
      chk(32'(rx_status_size_dw), 32'(r / 16));
    end
    power_save_exit <= 1'b1;
    @(posedge sys_clk);
    power_save_exit <= 1'b0;
    wr(`HWC_ADDR, 32'h0003_0000);
    wr(`RDP_ADDR, 32'h8000_0000);
    rd(`HWC_ADDR, 32'h000E_0000);
    wr(`HWC_ADDR, 32'h0008_0000);
    rd(8'hA0, 32'h0);
    chk(32'(e), 32'h1);
  endtask
  // Soft reset with stopped PHY times out; interrupt masked then raised and cleared.
  task test_timeout;
    phy_clocks_running <= 1'b0;
    wr(`HWC_ADDR, 32'h0008_0001);
    repeat (300) @(posedge sys_clk);
    rd(`HWC_ADDR, 32'h0008_0002);
    rd(`IST_ADDR, 32'h1);
    chk(32'(irq), 32'h0);
    wr(`IMASK_ADDR, 32'h1);
    // The interrupt follows the mask one cycle after the write lands.
    @(posedge sys_clk);
    chk(32'(irq), 32'h1);
    wr(`IST_ADDR, 32'h1);
    chk(32'(irq), 32'h0);
    rd(`IST_ADDR, 32'h0);
  endtask
  // Retry with running PHY completes and clears the time-out flag.
  task test_reset_ok;
    phy_clocks_running <= 1'b1;
    wr(`HWC_ADDR, 32'h0008_0001);
    poll(`HWC_ADDR, 32'h1);
    chk(q, 32'h0008_0000);
    rd(`IST_ADDR, 32'h8);
    wr(`IST_ADDR, 32'hF);
  endtask
  // Skip bit reads high until done; reserved bits read zero.
  task test_skip;
    wr(`RDP_ADDR, 32'hFFFF_FFFF);
    rd(`RDP_ADDR, 32'h8000_0000);
    poll(`RDP_ADDR, 32'h8000_0000);
    chk(q, 32'h0);
    rd(`IST_ADDR, 32'h4);
    wr(`IST_ADDR, 32'h4);
  endtask
  // Full at the 4-DWORD margin, overrun drops, then drain and a clean frame.
  task test_rx;
    rx_fifo_used_dw <= 12'd1916;
    frame(40);
    frame(2);
    repeat (10) @(posedge sys_clk);
    chk(32'(pushes), 32'h0);
    rd(`DROP_ADDR, 32'h2);
    rd(`IST_ADDR, 32'h2);
    rx_fifo_used_dw <= 12'd1915;
    repeat (50) @(posedge sys_clk);
    chk(32'(pushes != 0), 32'h1);
    pushes = 0;
    lasts = 0;
    rx_fifo_used_dw <= 12'h000;
    frame(3);
    repeat (10) @(posedge sys_clk);
    chk(32'(pushes), 32'h3);
    chk(32'(lasts), 32'h1);
    chk(rxd_seen, 32'h102);
  endtask
  // Four transmit words reach the MAC while it stalls; the last one taken is A3.
  task test_tx;
    stall <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      tx_fifo_valid <= 1'b1;
      tx_fifo_data <= 32'(i) + 32'hA0;
      @(posedge sys_clk);
      while (tx_fifo_ready !== 1'b1) @(posedge sys_clk);
    end
    tx_fifo_valid <= 1'b0;
    repeat (20) @(posedge sys_clk);
    chk(32'(tx_count), 32'h4);
    chk(tx_last, 32'hA3);
  endtask
  // Main sequence.
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, power_save_exit, stall} = 5'h00;
    {tx_fifo_valid, rx_mac_valid, rx_mac_last} = 3'h0;
    phy_clocks_running = 1'b1;
    paddr = 8'h00;
    {pwdata, tx_fifo_data, rx_mac_data} = {3{32'h0}};
    rx_fifo_used_dw = 12'h000;
    {mismatches, check_count, cycles, pushes, lasts} = {5{32'h0}};
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    test_alloc;
    test_timeout;
    test_reset_ok;
    test_skip;
    test_rx;
    test_tx;
    stop_test;
  end
endmodule // mac_fifo_allocation_and_soft_reset_tb
`default_nettype wire
